// ### design/frame_sync_pulse_generator.sv
// frame sync pulse generator with its configuration registers and shared pin control
// Behaviour
// RULE1: pulse is produced on the shared pin only while serial output mode is active.
// RULE2: rising edge is delayed by the 24-bit lag register in every mode.
// RULE3: in modes 1 and 2 the pulse length comes from the 16-bit length register.
// RULE4: one count of lag or length equals one system clock cycle.
// RULE5: mode 1 triggers the pulse on the start-of-frame event.
// RULE6: mode 2 triggers the pulse on the end-of-frame event.
// RULE7: mode 3 builds the pulse from end-of-frame and start-of-frame together.
// RULE8: mode 3 is long; length counts from start-of-frame to the falling edge.
// RULE9: shared pin is either sync input or pulse output, never both.
// RULE10: pin floats in shutdown, after release and in standby unless configured.
// RULE11: shutdown input held low keeps the block in reset.
// RULE12: frames need at least four dummy lines; short blanking is flagged.
// RULE13: direction register bit 1 picks input (0) or output (1).
// RULE14: source register bit 1 picks pulse path (0) or software level (1).
// RULE15: value register bit 1 is the level driven when software source chosen.
// RULE16: lag counts from the trigger; zero lag rises on the next clock.
module frame_sync_pulse_generator (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  input  wire logic        HW_POWERDOWN_N_I,
  input  wire logic        MIPI_MODE_I,
  input  wire logic        STANDBY_I,
  input  wire logic        SOF_I,
  input  wire logic        EOF_I,
  input  wire logic        LINE_END_I,
  input  wire logic [15:0] REG_ADDR_I,
  input  wire logic [7:0]  REG_WDATA_I,
  input  wire logic        REG_WE_I,
  input  wire logic        REG_RE_I,
  output logic [7:0]       REG_RDATA_O,
  input  wire logic        FRAME_SYNC_IN_I,
  output logic             FRAME_SYNC_O,
  output logic             VSYNC_O,
  output logic             VSYNC_OE_N_O
);

  // =====================================================================
  // state encoding and reset
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAG  = 2'b01,
    ST_HIGH = 2'b10,
    ST_WAIT = 2'b11
  } state_t;

  logic rst;
  // shutdown low acts like the async reset: registers return to defaults
  assign rst = RST_I | ~HW_POWERDOWN_N_I; // RULE11

  // =====================================================================
  // registers
  fsync_pkg::cfg_t cfg_q;
  logic            short_blank_q;
  logic [3:0]      blank_lines_q;
  logic            in_blank_q;
  logic            blank_rd;
  logic            short_set;

  assign blank_rd = REG_RE_I & (REG_ADDR_I == fsync_pkg::BLANK_STAT_ADDR);

  always_ff @(posedge CLK_I or posedge rst)
  begin
    if (rst)
    begin
      cfg_q.mode       <= fsync_pkg::mode_t'(fsync_pkg::MODE_RST);
      cfg_q.stby_drive <= 1'b0;
      cfg_q.dir_out    <= 1'b0; // RULE10
      cfg_q.src_sw     <= 1'b0;
      cfg_q.sw_level   <= 1'b0;
      cfg_q.length     <= fsync_pkg::LENGTH_RST;
      cfg_q.lag        <= fsync_pkg::LAG_RST;
    end
    else if (REG_WE_I)
    begin
      if (REG_ADDR_I == fsync_pkg::IO_DIR_ADDR)
        cfg_q.dir_out <= REG_WDATA_I[fsync_pkg::PIN_BIT]; // RULE13
      else if (REG_ADDR_I == fsync_pkg::IO_SRC_ADDR)
        cfg_q.src_sw <= REG_WDATA_I[fsync_pkg::PIN_BIT]; // RULE14
      else if (REG_ADDR_I == fsync_pkg::IO_VALUE_ADDR)
        cfg_q.sw_level <= REG_WDATA_I[fsync_pkg::PIN_BIT]; // RULE15
      else if (REG_ADDR_I == fsync_pkg::PULSE_CTRL_ADDR)
      begin
        cfg_q.mode       <= fsync_pkg::mode_t'(REG_WDATA_I[fsync_pkg::MODE_LSB +: 2]);
        cfg_q.stby_drive <= REG_WDATA_I[fsync_pkg::STBY_DRIVE_BIT];
      end
      else if (REG_ADDR_I == fsync_pkg::LENGTH_HI_ADDR)
        cfg_q.length[15:8] <= REG_WDATA_I; // RULE3
      else if (REG_ADDR_I == fsync_pkg::LENGTH_LO_ADDR)
        cfg_q.length[7:0] <= REG_WDATA_I;
      else if (REG_ADDR_I == fsync_pkg::LAG_HI_ADDR)
        cfg_q.lag[23:16] <= REG_WDATA_I; // RULE2
      else if (REG_ADDR_I == fsync_pkg::LAG_MID_ADDR)
        cfg_q.lag[15:8] <= REG_WDATA_I;
      else if (REG_ADDR_I == fsync_pkg::LAG_LO_ADDR)
        cfg_q.lag[7:0] <= REG_WDATA_I;
    end
  end

  // =====================================================================
  // read port; unmapped addresses read zero
  logic [7:0] rd_mux;

  assign rd_mux =
    (REG_ADDR_I == fsync_pkg::IO_DIR_ADDR)     ? {6'h00, cfg_q.dir_out, 1'b0} :
    (REG_ADDR_I == fsync_pkg::IO_SRC_ADDR)     ? {6'h00, cfg_q.src_sw, 1'b0} :
    (REG_ADDR_I == fsync_pkg::IO_VALUE_ADDR)   ? {6'h00, cfg_q.sw_level, 1'b0} :
    (REG_ADDR_I == fsync_pkg::PULSE_CTRL_ADDR) ? {5'h00, cfg_q.stby_drive, cfg_q.mode} :
    (REG_ADDR_I == fsync_pkg::LENGTH_HI_ADDR)  ? cfg_q.length[15:8] :
    (REG_ADDR_I == fsync_pkg::LENGTH_LO_ADDR)  ? cfg_q.length[7:0] :
    (REG_ADDR_I == fsync_pkg::BLANK_STAT_ADDR) ? {short_blank_q, 3'h0, blank_lines_q} :
    (REG_ADDR_I == fsync_pkg::LAG_HI_ADDR)     ? cfg_q.lag[23:16] :
    (REG_ADDR_I == fsync_pkg::LAG_MID_ADDR)    ? cfg_q.lag[15:8] :
    (REG_ADDR_I == fsync_pkg::LAG_LO_ADDR)     ? cfg_q.lag[7:0] : 8'h00;

  always_ff @(posedge CLK_I or posedge rst)
  begin
    if (rst)
      REG_RDATA_O <= 8'h00;
    else if (REG_RE_I)
      REG_RDATA_O <= rd_mux;
  end

  // =====================================================================
  // blanking check: lines between end and start of frame
  // a frame start seen too soon sets the flag; a set beats the read-clear
  assign short_set = SOF_I & in_blank_q & (blank_lines_q < fsync_pkg::MIN_DUMMY_LINES); // RULE12

  always_ff @(posedge CLK_I or posedge rst)
  begin
    if (rst)
    begin
      in_blank_q    <= 1'b0;
      blank_lines_q <= 4'h0;
      short_blank_q <= 1'b0;
    end
    else
    begin
      if (EOF_I)
      begin
        in_blank_q    <= 1'b1;
        blank_lines_q <= 4'h0;
      end
      else if (SOF_I)
        in_blank_q <= 1'b0;
      else if (in_blank_q & LINE_END_I & (blank_lines_q != 4'hf))
        blank_lines_q <= blank_lines_q + 4'h1;
      short_blank_q <= short_set | (short_blank_q & ~blank_rd);
    end
  end

  // =====================================================================
  // pulse sequencer
  state_t      state_q;
  state_t      state_d;
  logic        vsync_q;
  logic        vsync_d;
  logic        trig;
  logic        long_mode;
  logic        cnt_load;
  logic [23:0] cnt_value;
  logic        cnt_last;
  logic [23:0] length_ext;
  logic        lag_zero;

  assign long_mode  = (cfg_q.mode == fsync_pkg::MODE_LONG);
  assign trig       = MIPI_MODE_I & // RULE1
                      (((cfg_q.mode == fsync_pkg::MODE_SOF) & SOF_I) | // RULE5
                       ((cfg_q.mode == fsync_pkg::MODE_EOF) & EOF_I) | // RULE6
                       (long_mode & EOF_I)); // RULE7
  assign lag_zero   = (cfg_q.lag == 24'h000000);
  assign length_ext = {8'h00, cfg_q.length};

  // one counter serves lag and length; a zero length still gives a one-cycle pulse
  always_comb
  begin
    state_d   = state_q;
    vsync_d   = vsync_q;
    cnt_load  = 1'b0;
    cnt_value = length_ext;
    case (state_q)
      ST_IDLE:
        if (trig)
        begin
          cnt_load = 1'b1;
          if (lag_zero)
          begin
            vsync_d = 1'b1; // RULE16
            state_d = long_mode ? ST_WAIT : ST_HIGH;
          end
          else
          begin
            cnt_value = cfg_q.lag; // RULE2
            state_d   = ST_LAG;
          end
        end
      ST_LAG:
        if (cnt_last) // RULE4
        begin
          vsync_d  = 1'b1;
          cnt_load = 1'b1;
          state_d  = long_mode ? ST_WAIT : ST_HIGH;
        end
      ST_WAIT:
        if (SOF_I)
        begin
          cnt_load = 1'b1; // RULE8
          state_d  = ST_HIGH;
        end
      ST_HIGH:
        if (cnt_last) // RULE3
        begin
          vsync_d = 1'b0;
          state_d = ST_IDLE;
        end
      default:
        state_d = ST_IDLE;
    endcase
    if (!MIPI_MODE_I)
    begin
      vsync_d = 1'b0; // RULE1
      state_d = ST_IDLE;
    end
  end

  step_counter #(
    .W (24)
  ) u_step_counter (
    .clk_i   (CLK_I),
    .rst_i   (rst),
    .load_i  (cnt_load),
    .value_i (cnt_value),
    .last_o  (cnt_last)
  );

  // =====================================================================
  // shared pin
  logic drive_en;
  logic pin_level;

  // standby floats the pin unless software asked to keep driving it
  assign drive_en  = cfg_q.dir_out & ~(STANDBY_I & ~cfg_q.stby_drive); // RULE9 RULE10
  assign pin_level = cfg_q.src_sw ? cfg_q.sw_level : vsync_q; // RULE14 RULE15

  always_ff @(posedge CLK_I or posedge rst)
  begin
    if (rst)
    begin
      state_q      <= ST_IDLE;
      vsync_q      <= 1'b0;
      VSYNC_O      <= 1'b0;
      VSYNC_OE_N_O <= 1'b1; // RULE10
      FRAME_SYNC_O <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      vsync_q      <= vsync_d;
      VSYNC_O      <= pin_level;
      VSYNC_OE_N_O <= ~drive_en;
      FRAME_SYNC_O <= FRAME_SYNC_IN_I & ~cfg_q.dir_out; // RULE9
    end
  end

endmodule // frame_sync_pulse_generator

// ### design/fsync_pkg.sv
// package: register map, field positions, reset values and types of the frame sync pulse block
package fsync_pkg;

  // =====================================================================
  // register offsets (byte addresses of the 16-bit register space)
  localparam logic [15:0] IO_DIR_ADDR     = 16'h3005;
  localparam logic [15:0] IO_VALUE_ADDR   = 16'h3009;
  localparam logic [15:0] IO_SRC_ADDR     = 16'h3027;
  localparam logic [15:0] PULSE_CTRL_ADDR = 16'h4310;
  localparam logic [15:0] LENGTH_HI_ADDR  = 16'h4311;
  localparam logic [15:0] LENGTH_LO_ADDR  = 16'h4312;
  localparam logic [15:0] BLANK_STAT_ADDR = 16'h4313;
  localparam logic [15:0] LAG_HI_ADDR     = 16'h4314;
  localparam logic [15:0] LAG_MID_ADDR    = 16'h4315;
  localparam logic [15:0] LAG_LO_ADDR     = 16'h4316;

  // =====================================================================
  // field positions
  localparam int PIN_BIT        = 1;
  localparam int MODE_LSB       = 0;
  localparam int STBY_DRIVE_BIT = 2;
  localparam int SHORT_BLANK_BIT = 7;

  // =====================================================================
  // reset values and blanking threshold
  localparam logic [1:0]  MODE_RST   = 2'h1;
  localparam logic [15:0] LENGTH_RST = 16'h0001;
  localparam logic [23:0] LAG_RST    = 24'h000000;
  localparam logic [3:0]  MIN_DUMMY_LINES = 4'h4;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SOF = 2'b01,
    MODE_EOF = 2'b10,
    MODE_LONG = 2'b11
  } mode_t;

  typedef struct packed {
    mode_t       mode;
    logic        stby_drive;
    logic        dir_out;
    logic        src_sw;
    logic        sw_level;
    logic [15:0] length;
    logic [23:0] lag;
  } cfg_t;

endpackage

// ### design/step_counter.sv
// loadable down counter that times the lag and length of the pulse in clock cycles
module step_counter #(
  parameter int W = 24
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              last_o
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // one step per system clock
  assign cnt_d  = load_i ? value_i : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
  assign last_o = (cnt_q <= {{(W-1){1'b0}}, 1'b1});

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule // step_counter

// ### dv/frame_sync_pulse_generator_test.sv
// testbench: registers, pulse modes, pin control and shutdown of the frame sync generator
module frame_sync_pulse_generator_test;
  timeunit 1ns;
  timeprecision 1ps;
  // starts low so no false falling edge at time zero shortens the reset hold
  logic        clk = 1'b0;
  logic        rst, pdn, mipi, stby, sof, eof, le, we, re, hen, hval;
  logic        fso, vs, oen, pin;
  logic [15:0] addr;
  logic [7:0]  wd, rd, pulses;
  logic [16:0] seed;
  int          errors, checks;

  frame_sync_pulse_generator frame_sync_pulse_generator_inst (
    .CLK_I(clk), .RST_I(rst), .HW_POWERDOWN_N_I(pdn), .MIPI_MODE_I(mipi),
    .STANDBY_I(stby), .SOF_I(sof), .EOF_I(eof), .LINE_END_I(le), .REG_ADDR_I(addr),
    .REG_WDATA_I(wd), .REG_WE_I(we), .REG_RE_I(re), .REG_RDATA_O(rd),
    .FRAME_SYNC_IN_I(pin), .FRAME_SYNC_O(fso), .VSYNC_O(vs), .VSYNC_OE_N_O(oen));
  fsync_host_model fsync_host_model_inst (.clk_i(clk), .oe_n_i(oen), .drive_i(vs),
    .host_en_i(hen), .host_val_i(hval), .pin_o(pin), .pulses_o(pulses));

  // ==================================================================
  // helpers
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  function automatic logic [23:0] width_of(input logic [15:0] n);
    return (n == 16'h0000) ? 24'h000001 : {8'h00, n};
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    we = 1'b1;
    tick(1);
    we = 1'b0;
    // let an edge pass so a following call never retoggles the strobe in one step
    tick(1);
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
    addr = a;
    re = 1'b1;
    tick(1);
    re = 1'b0;
    check({16'h0000, rd}, {16'h0000, e});
    tick(1);
  endtask
  task automatic pulse(input logic [1:0] m, input logic [23:0] lag, input logic [15:0] len);
    int k;
    k = 0;
    wr(16'h4310, {6'h00, m});
    wr(16'h4314, lag[23:16]);
    wr(16'h4315, lag[15:8]);
    wr(16'h4316, lag[7:0]);
    wr(16'h4311, len[15:8]);
    wr(16'h4312, len[7:0]);
    if (m == 2'h1)
      sof = 1'b1;
    else
      eof = 1'b1;
    tick(1);
    {sof, eof} = 2'b00;
    while (!vs && k < 2000)
    begin
      tick(1);
      k++;
    end
    check(24'(k), lag + 24'h1);
    k = 0;
    if (m == 2'h3)
    begin
      tick(2);
      sof = 1'b1;
      tick(1);
      sof = 1'b0;
    end
    while (vs && k < 2000)
    begin
      tick(1);
      k++;
    end
    check(24'(k), width_of(len) + ((m == 2'h3) ? 24'h1 : 24'h0));
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==================================================================
  // clock, watchdog and test sequence
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial
  begin
    {rst, pdn, mipi, stby, sof, eof, le, we, re, hen, hval} = 11'h700;
    {addr, wd, errors, checks, seed} = {24'h000000, 64'h0, 17'h180b8};
    tick(20);
    rst = 1'b0;
    tick(1);
    rdchk(16'h4312, 8'h01);
    rdchk(16'h4316, 8'h00);
    rdchk(16'h0000, 8'h00);
    check(oen, 1'b1);
    $display("reset test done");
    wr(16'h3005, 8'h02);
    pulse(2'h1, 24'h0, 16'h0);
    pulse(2'h2, 24'h000100, 16'h0003);
    pulse(2'h3, 24'h0, 16'h0001);
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      pulse(2'(i % 3 + 1), {19'h0, seed[4:0]}, {12'h0, seed[8:5]} | 16'(i % 3 == 2));
    end
    check(pulses, 8'h0f);
    mipi = 1'b0;
    wr(16'h4310, 8'h01);
    sof = 1'b1;
    tick(1);
    sof = 1'b0;
    tick(10);
    check(pulses, 8'h0f);
    mipi = 1'b1;
    wr(16'h4310, 8'h00);
    {sof, eof} = 2'b11;
    tick(1);
    {sof, eof} = 2'b00;
    tick(10);
    check(pulses, 8'h0f);
    $display("pulse test done");
    stby = 1'b1;
    tick(3);
    check(oen, 1'b1);
    wr(16'h4310, 8'h05);
    tick(2);
    check(oen, 1'b0);
    stby = 1'b0;
    wr(16'h3027, 8'h02);
    wr(16'h3009, 8'h02);
    tick(2);
    check(pin, 1'b1);
    check(fso, 1'b0);
    wr(16'h3009, 8'h00);
    tick(2);
    check(pin, 1'b0);
    wr(16'h3005, 8'h00);
    {hen, hval} = 2'b11;
    tick(4);
    check({oen, fso}, 2'b11);
    $display("pin test done");
    eof = 1'b1;
    tick(1);
    eof = 1'b0;
    repeat (2)
    begin
      le = 1'b1;
      tick(1);
      le = 1'b0;
      tick(1);
    end
    sof = 1'b1;
    tick(1);
    sof = 1'b0;
    tick(2);
    rdchk(16'h4313, 8'h82);
    rdchk(16'h4313, 8'h02);
    wr(16'h3005, 8'h02);
    pdn = 1'b0;
    tick(2);
    check(oen, 1'b1);
    pdn = 1'b1;
    tick(1);
    rdchk(16'h3005, 8'h00);
    $display("blanking and shutdown test done");
    complete_run();
  end
endmodule // frame_sync_pulse_generator_test

// ### dv/fsync_gen_asserts.sv
// checker: pin control and pulse timing of the frame sync generator
module fsync_gen_asserts (
  input wire logic        CLK_I,
  input wire logic        RST_I,
  input wire logic        HW_POWERDOWN_N_I,
  input wire logic        MIPI_MODE_I,
  input wire logic        STANDBY_I,
  input wire logic        SOF_I,
  input wire logic        EOF_I,
  input wire logic [15:0] REG_ADDR_I,
  input wire logic [7:0]  REG_WDATA_I,
  input wire logic        REG_WE_I,
  input wire logic [7:0]  REG_RDATA_O,
  input wire logic        FRAME_SYNC_O,
  input wire logic        VSYNC_O,
  input wire logic        VSYNC_OE_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==================================================================
  // shadow of the configuration, updated on the same edge as the design
  logic [15:0] len_q;
  logic [23:0] lag_q;
  logic [1:0]  mode_q;
  logic        dir_q, src_q, lvl_q, stby_q;
  logic [16:0] hcnt_q, scnt_q;
  wire  [16:0] len_w = (len_q == 16'h0000) ? 17'h00001 : {1'b0, len_q};
  wire         trig_w = (mode_q == 2'h1) ? SOF_I : EOF_I;

  always_ff @(posedge CLK_I or posedge RST_I or negedge HW_POWERDOWN_N_I)
    if (RST_I || !HW_POWERDOWN_N_I)
    begin
      {len_q, lag_q, mode_q} <= {16'h0001, 24'h000000, 2'h1};
      {dir_q, src_q, lvl_q, stby_q, hcnt_q, scnt_q} <= '0;
    end
    else
    begin
      hcnt_q <= VSYNC_O ? hcnt_q + 17'h00001 : 17'h00000;
      scnt_q <= SOF_I ? 17'h00001 : scnt_q + 17'h00001;
      if (REG_WE_I)
        case (REG_ADDR_I)
          16'h3005: dir_q <= REG_WDATA_I[1];
          16'h3009: lvl_q <= REG_WDATA_I[1];
          16'h3027: src_q <= REG_WDATA_I[1];
          16'h4310: {stby_q, mode_q} <= REG_WDATA_I[2:0];
          16'h4311: len_q[15:8] <= REG_WDATA_I;
          16'h4312: len_q[7:0] <= REG_WDATA_I;
          16'h4314: lag_q[23:16] <= REG_WDATA_I;
          16'h4315: lag_q[15:8] <= REG_WDATA_I;
          16'h4316: lag_q[7:0] <= REG_WDATA_I;
          default: ;
        endcase
    end

  // ==================================================================
  // properties
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I || !HW_POWERDOWN_N_I);
  sequence s_quiet;
    (!MIPI_MODE_I && !src_q) [*3];
  endsequence

  a_shutdown_float: assert property (
    disable iff (RST_I) !HW_POWERDOWN_N_I |-> VSYNC_OE_N_O && !VSYNC_O && REG_RDATA_O == 8'h00)
    else $error("pin driven or state kept in shutdown");
  a_dir_float: assert property (
    VSYNC_OE_N_O == !$past(dir_q && !(STANDBY_I && !stby_q)))
    else $error("pin enable disagrees with direction and standby");
  a_pin_exclusive: assert property (
    !VSYNC_OE_N_O [*3] |-> !FRAME_SYNC_O)
    else $error("sync input seen while pin drives");
  a_sw_level: assert property (
    $past(src_q && dir_q && MIPI_MODE_I) |-> VSYNC_O == $past(lvl_q))
    else $error("software level not on pin");
  a_mipi_gate: assert property (
    s_quiet |=> !VSYNC_O)
    else $error("pulse without serial mode");
  a_rise_trigger: assert property (
    $rose(VSYNC_O) && !$past(src_q) && lag_q == 24'h0 && mode_q != 2'h0 |-> $past(trig_w, 2))
    else $error("zero lag pulse not two cycles after its trigger");
  a_pulse_width: assert property (
    $fell(VSYNC_O) && !$past(src_q) && (mode_q == 2'h1 || mode_q == 2'h2) |-> hcnt_q == len_w)
    else $error("pulse width differs from length");
  a_long_fall: assert property (
    $fell(VSYNC_O) && !$past(src_q) && mode_q == 2'h3 |-> scnt_q == len_w + 17'h00002)
    else $error("long pulse fall not timed from frame start");
endmodule // fsync_gen_asserts

bind frame_sync_pulse_generator fsync_gen_asserts fsync_gen_asserts_inst (
  .CLK_I(CLK_I), .RST_I(RST_I), .HW_POWERDOWN_N_I(HW_POWERDOWN_N_I),
  .MIPI_MODE_I(MIPI_MODE_I), .STANDBY_I(STANDBY_I), .SOF_I(SOF_I), .EOF_I(EOF_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WE_I(REG_WE_I),
  .REG_RDATA_O(REG_RDATA_O), .FRAME_SYNC_O(FRAME_SYNC_O), .VSYNC_O(VSYNC_O),
  .VSYNC_OE_N_O(VSYNC_OE_N_O));

// ### dv/fsync_host_model.sv
// host side model: resolves the shared pin and counts the pulses it receives
module fsync_host_model (
  input  wire logic       clk_i,
  input  wire logic       oe_n_i,
  input  wire logic       drive_i,
  input  wire logic       host_en_i,
  input  wire logic       host_val_i,
  output logic            pin_o,
  output logic [7:0]      pulses_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flt_q;
  logic pin_q;
  // no pull on this pin: a floating level keeps changing so a stale value never passes
  assign pin_o = !oe_n_i ? drive_i : (host_en_i ? host_val_i : flt_q);
  initial {flt_q, pin_q, pulses_o} = '0;
  always @(posedge clk_i)
  begin
    flt_q <= ~flt_q;
    pin_q <= pin_o;
    if (!oe_n_i && pin_o && !pin_q)
      pulses_o <= pulses_o + 8'h01;
  end
endmodule // fsync_host_model
